// ### shared/cfg_consts.svh
// Constants of the configuration and serial control block.
// Included by the serial control design file; definitions only.
`ifndef CFG_CONSTS_SVH
`define CFG_CONSTS_SVH

`define DEV_ADDR      7'h6A
// Identification byte value is arbitrary
`define ID_BYTE       8'h5A
`define REG_COUNT     32
`define REG_AW        5
`define IMAGE_COUNT   6
`define NV_DEPTH      192
`define NV_AW         8
`define LAST_IMAGE    3'h5
`define OP_WRITE      2'h0
`define OP_SAVE       2'h1
`define OP_RESTORE    2'h2
`define CTRL_REG      8'h02
`define MODE_REG      8'h03
`define OSEL_REG      8'h04
`define OEN_REG       8'h05
`define OEM_REG       8'h06
`define POL_BIT       0
`define SHUT_BIT      1
`define PRIM_BIT      2
`define BYP_BIT       3
`define OUT_COUNT     4

`endif

// ### shared/cfg_pkg.sv
// Types of the configuration and serial control block.
// Assumes cfg_consts.svh on the include path.
package cfg_pkg;
	typedef enum logic [2:0] {S_IDLE, S_RX, S_RXACK, S_TX, S_TXACK} link_state_t;
	typedef enum logic [1:0] {P_ADDR, P_CMD, P_REG, P_DATA} phase_t;
endpackage

// ### rtl/cfg_byte_ram.sv
// Byte memory with one write port and a registered read port.
// Assumes one clock; contents clear under reset.
`timescale 1ns/1ps
`default_nettype none
module cfg_byte_ram #(
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input  wire logic          clock,
	input  wire logic          rst,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [7:0]    rdata
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= 8'h00;
		end
		else if (we && (int'(waddr) < DEPTH))
			mem[waddr] <= wdata;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			rdata <= 8'h00;
		else if (int'(raddr) < DEPTH)
			rdata <= mem[raddr];
		else
			rdata <= 8'h00;
	end
endmodule
`default_nettype wire

// ### rtl/cfg_serial_control.sv
// Two-wire register slave, nonvolatile save and restore, source and
// output-enable control of a clock generator.
// Assumes pins are asynchronous to clock; the link clock is sampled.
//
// Behaviour
// R1 - Select pins pick one of six stored images; codes 110, 111 reserved
// R2 - Master may rewrite configuration registers while running
// R3 - Primary-source bit swaps inputs; choice pin picks primary or secondary
// R4 - Bypass bit lets an external clock drive the reference input directly
// R5 - Switch mode 0x manual, 10 auto one-way, 11 auto revertive
// R6 - Shutdown pin active low when polarity bit 0, active high when 1
// R7 - With mode bit 0, pin suspends outputs enabled for suspension
// R8 - Output select 0 gives high impedance; mode 1, pin high: global stop
// R9 - Slave at address 1101010 with read and write formats
// R10 - First write byte after command sets pointer; pointer steps per byte
// R11 - Command low bits: 00 write, 01 save, 10 restore
// R12 - Write bytes land at successive addresses until stop
// R13 - Master sets read pointer with a write frame when not sequential
// R14 - Master may use repeated start after setting the pointer
// R15 - Read returns identification byte, then successive registers
// R16 - Save copies all registers out; restore reloads all of them
// R17 - Save or restore runs after stop; no acknowledges until done
// R18 - Other masters treat the bus busy during save or restore
// R19 - Automatic restore at power-up; ready once address is acknowledged
`include "cfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cfg_serial_control (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic [2:0] config_select,
	input  wire logic       source_choice_pin,
	input  wire logic       shutdown_enable_pin,
	input  wire logic       primary_lost,
	output logic            ref_from_clock_input,
	output logic            crystal_bypass,
	output logic [3:0]      out_enabled,
	output logic [3:0]      out_hiz,
	output logic [7:0]      disabled_level,
	output logic            global_shutdown,
	output logic            nv_busy
);
	import cfg_pkg::*;

	logic [7:0] meta;
	logic [7:0] syncd;
	logic       scl_q;
	logic       sda_q;
	logic       scl_s;
	logic       sda_s;
	logic [2:0] sel_s;
	logic [2:0] sel_q;
	logic       start_c;
	logic       stop_c;
	logic       rise;
	logic       fall;

	link_state_t state;
	phase_t      phase;
	logic [7:0]  shreg;
	logic [3:0]  cnt;
	logic [7:0]  ptr;
	logic        rw;
	logic        acked;
	logic [1:0]  op;
	logic        op_pending;
	logic        nv_start;
	logic        s_we;
	logic [7:0]  s_wa;
	logic [7:0]  s_wd;

	logic        save_dir;
	logic        restore_pend;
	logic [2:0]  image;
	logic [5:0]  idx;
	logic [4:0]  widx;
	logic        rd_v;

	logic              reg_we;
	logic [`REG_AW-1:0] reg_wa;
	logic [7:0]        reg_wd;
	logic [`REG_AW-1:0] reg_ra;
	logic [7:0]        reg_rd;
	logic              nv_we;
	logic [7:0]        nv_rd;

	logic [7:0] ctrl;
	logic [1:0] mode;
	logic [3:0] osel;
	logic [3:0] pin_enable_bit;
	logic [7:0] oem;
	logic       sw_sec;

	localparam logic [7:0] id_value = `ID_BYTE;

	function automatic logic in_map(input logic [7:0] a);
		in_map = (int'(a) < `REG_COUNT);
	endfunction

	function automatic logic [`NV_AW-1:0] nv_addr(input logic [2:0] img,
		input logic [4:0] i);
		nv_addr = {img, i};
	endfunction

	// Pins are asynchronous: two stages before any use
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			meta <= 8'h03;
			syncd <= 8'h03;
		end
		else
		begin
			meta <= {primary_lost, shutdown_enable_pin, source_choice_pin,
				config_select, sda_in, scl};
			syncd <= meta;
		end
	end

	assign scl_s = syncd[0];
	assign sda_s = syncd[1];
	assign sel_s = syncd[4:2];

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign start_c = scl_s && scl_q && sda_q && !sda_s;
	assign stop_c = scl_s && scl_q && !sda_q && sda_s;
	assign rise = scl_s && !scl_q;
	assign fall = !scl_s && scl_q;

	// Serial slave; sda_out stays low, sda_oe pulls the line
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state <= S_IDLE;
			phase <= P_ADDR;
			shreg <= 8'h00;
			cnt <= 4'h0;
			ptr <= 8'h00;
			rw <= 1'b0;
			acked <= 1'b0;
			op <= `OP_WRITE;
			op_pending <= 1'b0;
			nv_start <= 1'b0;
			s_we <= 1'b0;
			s_wa <= 8'h00;
			s_wd <= 8'h00;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end
		else
		begin
			s_we <= 1'b0;
			nv_start <= 1'b0;
			if (start_c)
			begin
				state <= S_RX;
				phase <= P_ADDR;
				cnt <= 4'h0;
				sda_oe <= 1'b0;
			end
			else if (stop_c)
			begin
				state <= S_IDLE;
				sda_oe <= 1'b0;
				nv_start <= op_pending; // [R17]
				op_pending <= 1'b0;
			end
			else
			begin
				case (state)
				S_RX:
				begin
					if (rise && cnt < 4'h8)
					begin
						shreg <= {shreg[6:0], sda_s};
						cnt <= cnt + 4'h1;
					end
					else if (fall && cnt == 4'h8)
					begin
						state <= S_RXACK;
						sda_oe <= 1'b1;
						case (phase)
						P_ADDR:
						begin
							rw <= shreg[0];
							// Silent while busy, so the master sees no ack
							if (shreg[7:1] != `DEV_ADDR || nv_busy) // [R9] [R17] [R19]
							begin
								state <= S_IDLE;
								sda_oe <= 1'b0;
							end
						end
						P_CMD:
						begin
							op <= shreg[1:0]; // [R11]
							op_pending <= (shreg[1:0] == `OP_SAVE) ||
								(shreg[1:0] == `OP_RESTORE);
						end
						P_REG:
						begin
							ptr <= shreg; // [R10]
							op_pending <= 1'b0;
						end
						default:
						begin
							s_we <= 1'b1; // [R2] [R12]
							s_wa <= ptr;
							s_wd <= shreg;
							ptr <= ptr + 8'h01; // [R10]
						end
						endcase
					end
				end
				S_RXACK:
				begin
					if (fall)
					begin
						cnt <= 4'h0;
						if (phase == P_ADDR && rw)
						begin
							state <= S_TX;
							shreg <= `ID_BYTE; // [R15]
							sda_oe <= !id_value[7];
						end
						else
						begin
							state <= S_RX;
							sda_oe <= 1'b0;
							case (phase)
							P_ADDR: phase <= P_CMD;
							P_CMD: phase <= P_REG;
							default: phase <= P_DATA;
							endcase
						end
					end
				end
				S_TX:
				begin
					if (fall)
					begin
						if (cnt == 4'h7)
						begin
							state <= S_TXACK;
							sda_oe <= 1'b0;
						end
						else
						begin
							sda_oe <= !shreg[6];
							shreg <= {shreg[6:0], 1'b0};
							cnt <= cnt + 4'h1;
						end
					end
				end
				S_TXACK:
				begin
					if (rise)
						acked <= !sda_s;
					else if (fall)
					begin
						if (acked)
						begin
							// Unmapped addresses read as zero
							shreg <= in_map(ptr) ? reg_rd : 8'h00; // [R15]
							sda_oe <= in_map(ptr) ? !reg_rd[7] : 1'b1;
							ptr <= ptr + 8'h01; // [R10]
							cnt <= 4'h0;
							state <= S_TX;
						end
						else
							state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
				endcase
			end
		end
	end

	// Copy engine; one byte per cycle behind a one-cycle read
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			nv_busy <= 1'b0;
			save_dir <= 1'b0;
			restore_pend <= 1'b1; // [R19]
			image <= 3'h0;
			idx <= 6'h00;
			widx <= 5'h00;
			rd_v <= 1'b0;
			sel_q <= 3'h0;
		end
		else
		begin
			sel_q <= sel_s;
			if (!nv_busy && (nv_start || restore_pend))
			begin
				nv_busy <= 1'b1;
				save_dir <= nv_start && (op == `OP_SAVE); // [R16]
				// Reserved codes fall back to the first image
				image <= (sel_s > `LAST_IMAGE) ? 3'h0 : sel_s; // [R1]
				idx <= 6'h00;
				rd_v <= 1'b0;
				restore_pend <= (sel_s != sel_q) ||
					(restore_pend && nv_start);
			end
			else
			begin
				if (sel_s != sel_q)
					restore_pend <= 1'b1; // [R1]
				if (nv_busy)
				begin
					rd_v <= (int'(idx) < `REG_COUNT);
					widx <= idx[4:0];
					idx <= idx + 6'h01;
					if (int'(idx) == `REG_COUNT)
						nv_busy <= 1'b0; // [R16]
				end
			end
		end
	end

	assign reg_we = nv_busy ? (rd_v && !save_dir) : (s_we && in_map(s_wa));
	assign reg_wa = nv_busy ? widx : s_wa[`REG_AW-1:0];
	assign reg_wd = nv_busy ? nv_rd : s_wd;
	assign reg_ra = nv_busy ? idx[4:0] : ptr[`REG_AW-1:0];
	assign nv_we = nv_busy && rd_v && save_dir;

	cfg_byte_ram #(.DEPTH(`REG_COUNT), .AW(`REG_AW)) regs (
		.clock (clock),
		.rst   (rst),
		.we    (reg_we),
		.waddr (reg_wa),
		.wdata (reg_wd),
		.raddr (reg_ra),
		.rdata (reg_rd)
	);

	cfg_byte_ram #(.DEPTH(`NV_DEPTH), .AW(`NV_AW)) store (
		.clock (clock),
		.rst   (rst),
		.we    (nv_we),
		.waddr (nv_addr(image, widx)),
		.wdata (reg_rd),
		.raddr (nv_addr(image, idx[4:0])),
		.rdata (nv_rd)
	);

	// Shadows of the control registers the logic reads every cycle
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ctrl <= 8'h00;
			mode <= 2'h0;
			osel <= 4'h0;
			pin_enable_bit <= 4'h0;
			oem <= 8'h00;
		end
		else if (reg_we)
		begin
			if ({3'h0, reg_wa} == `CTRL_REG)
				ctrl <= reg_wd;
			else if ({3'h0, reg_wa} == `MODE_REG)
				mode <= reg_wd[1:0];
			else if ({3'h0, reg_wa} == `OSEL_REG)
				osel <= reg_wd[3:0];
			else if ({3'h0, reg_wa} == `OEN_REG)
				pin_enable_bit <= reg_wd[3:0];
			else if ({3'h0, reg_wa} == `OEM_REG)
				oem <= reg_wd;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			sw_sec <= 1'b0;
		else if (!mode[1])
			sw_sec <= syncd[5]; // [R3] [R5]
		else if (!sw_sec && syncd[7])
			sw_sec <= 1'b1; // [R5]
		else if (sw_sec && mode[0] && !syncd[7])
			sw_sec <= 1'b0; // [R5]
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ref_from_clock_input <= 1'b0;
			crystal_bypass <= 1'b0;
			out_enabled <= 4'h0;
			out_hiz <= 4'hF;
			disabled_level <= 8'h00;
			global_shutdown <= 1'b0;
		end
		else
		begin
			ref_from_clock_input <= sw_sec ^ ctrl[`PRIM_BIT]; // [R3]
			crystal_bypass <= ctrl[`BYP_BIT]; // [R4]
			disabled_level <= oem;
			global_shutdown <= ctrl[`SHUT_BIT] && syncd[6]; // [R8]
			for (int n = 0; n < `OUT_COUNT; n++)
			begin
				out_hiz[n] <= !osel[n] &&
					!(ctrl[`SHUT_BIT] && syncd[6]); // [R8]
				if (ctrl[`SHUT_BIT])
					out_enabled[n] <= !syncd[6] && osel[n] &&
						!(pin_enable_bit[n] && ctrl[`POL_BIT]); // [R8]
				else
					// Pin away from its active level suspends
					out_enabled[n] <= osel[n] && !(pin_enable_bit[n] &&
						(syncd[6] != ctrl[`POL_BIT])); // [R6] [R7]
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/cfg_serial_control_chk.sv
// Port-level checks of the serial control block.
// Bound to every cfg_serial_control instance; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module cfg_serial_control_chk (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       scl,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       shutdown_enable_pin,
	input wire logic [3:0] out_enabled,
	input wire logic [3:0] out_hiz,
	input wire logic       global_shutdown,
	input wire logic       nv_busy
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	chk_line_pull_only: assert property (sda_out == 1'b0)
		else $error("sda_out drives high");
	chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
		else $error("sda_oe moved while scl high");
	chk_ack_stands: assert property ($rose(sda_oe) |-> sda_oe[*8])
		else $error("sda_oe too short");
	chk_copy_bounded: assert property
		($rose(nv_busy) |-> ##[30:200] !nv_busy)
		else $error("copy length out of range");
	chk_quiet_copy: assert property (nv_busy |-> !sda_oe)
		else $error("line driven during copy");
	chk_powerup_copy: assert property ($fell(rst) |-> ##[0:2] nv_busy)
		else $error("no restore after reset");
	chk_global_off: assert property
		(global_shutdown |-> out_enabled == 4'h0 && out_hiz == 4'h0)
		else $error("outputs live in global shutdown");
	chk_global_pin: assert property
		($rose(global_shutdown) |-> shutdown_enable_pin)
		else $error("global shutdown without pin");
	chk_hiz_idle: assert property ((out_hiz & out_enabled) == 4'h0)
		else $error("output both enabled and high impedance");
	cov_copy: cover property ($rose(nv_busy));
	cov_ack: cover property ($rose(sda_oe));
	cov_global: cover property ($rose(global_shutdown));
endmodule
bind cfg_serial_control cfg_serial_control_chk u_chk (
	.clock              (clock),
	.rst                (rst),
	.scl                (scl),
	.sda_out            (sda_out),
	.sda_oe             (sda_oe),
	.shutdown_enable_pin(shutdown_enable_pin),
	.out_enabled        (out_enabled),
	.out_hiz            (out_hiz),
	.global_shutdown    (global_shutdown),
	.nv_busy            (nv_busy)
);
`default_nettype wire

// ### tb/i2c_master_model.sv
// Behavioural two-wire bus master, far side of the slave.
// Assumes the bench resolves sda with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	output logic     scl,
	output logic     sda_drv,
	input  wire logic sda
);
	logic [8:0] res;
	event       done;
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
		res = 9'h000;
	end
	// Data moves mid low phase so the sampled slave never sees a false stop
	task automatic bit_cycle(input logic b, output logic v);
		#12 sda_drv = b;
		#12 scl = 1'b1;
		#20 v = sda;
		#4 scl = 1'b0;
	endtask
	// Also serves as repeated start after a pointer set
	task automatic start();
		#12 sda_drv = 1'b1;
		#12 scl = 1'b1;
		#12 sda_drv = 1'b0;
		#12 scl = 1'b0;
	endtask
	// Clock stands high after a stop
	task automatic stop();
		#12 sda_drv = 1'b0;
		#12 scl = 1'b1;
		#12 sda_drv = 1'b1;
		#24;
	endtask
	// MSB first; ack_out 1 releases the line, so last read byte is a NACK
	task automatic xfer(input logic [7:0] d, input logic ack_out);
		logic v;
		for (int i = 7; i >= 0; i--)
		begin
			bit_cycle(d[i], v);
			res[i] = v;
		end
		bit_cycle(ack_out, v);
		res[8] = ~v;
		-> done;
	endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench of the serial control block.
// Assumes the bus master model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic [2:0] config_select = 3'h0;
	logic       source_choice_pin = 1'b0;
	logic       shutdown_enable_pin = 1'b0;
	logic       primary_lost = 1'b0;
	logic       scl, sda_drv, sda_out, sda_oe, ref_from_clock_input;
	logic       crystal_bypass, global_shutdown, nv_busy;
	logic [3:0] out_enabled, out_hiz;
	logic [7:0] disabled_level, rnd;
	logic [7:0] img [6];
	logic [3:0] tab [5] = '{4'hB, 4'h9, 4'hF, 4'hC, 4'h6};
	logic [8:0] expq [$];
	int         error_cnt = 0;
	int         check_count = 0;
	int         seed = 32'hF6022D6C;
	wire logic  sda = sda_drv & (sda_oe ? sda_out : 1'b1);
	always #2.5 clock = ~clock;
	i2c_master_model m (.scl(scl), .sda_drv(sda_drv), .sda(sda));
	cfg_serial_control DUT (
		.clock(clock), .rst(rst), .scl(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .config_select(config_select),
		.source_choice_pin(source_choice_pin),
		.shutdown_enable_pin(shutdown_enable_pin),
		.primary_lost(primary_lost),
		.ref_from_clock_input(ref_from_clock_input),
		.crystal_bypass(crystal_bypass), .out_enabled(out_enabled),
		.out_hiz(out_hiz), .disabled_level(disabled_level),
		.global_shutdown(global_shutdown), .nv_busy(nv_busy));
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [8:0] e, input logic [8:0] s);
		check_count++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	always @(m.done)
	begin
		if (expq.size() == 0)
			cmp("unexpected byte", ~m.res, m.res);
		else
			cmp("serial byte", expq.pop_front(), m.res);
	end
	task automatic b(input logic [7:0] d, input logic ex);
		expq.push_back({ex, d});
		m.xfer(d, 1'b1);
	endtask
	task automatic r(input logic [7:0] d, input logic last);
		expq.push_back({~last, d});
		m.xfer(8'hFF, last);
	endtask
	task automatic settle();
		repeat (12) @(negedge clock);
	endtask
	task automatic wait_busy(input logic lvl);
		for (int n = 0; n < 400 && nv_busy !== lvl; n++)
			@(negedge clock);
		if (nv_busy !== lvl)
		begin
			cmp("nv_busy wait", {8'h00, lvl}, {8'h00, nv_busy});
			print_verdict();
		end
	endtask
	task automatic head(input logic [7:0] op);
		m.start();
		b(8'hD4, 1'b1);
		b(op, 1'b1);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		head(8'h00);
		b(a, 1'b1);
		b(d, 1'b1);
		m.stop();
		settle();
	endtask
	task automatic copy(input logic [7:0] op);
		if (op != 8'h00)
			head(op);
		if (op != 8'h00)
			m.stop();
		wait_busy(1'b1);
		wait_busy(1'b0);
		settle();
		cmp("disabled_level", {1'b0, rnd}, {1'b0, disabled_level});
	endtask
	initial
	begin
		#400000;
		cmp("run time", 9'h000, 9'h1FF);
		print_verdict();
	end
	initial
	begin
		repeat (10) @(negedge clock);
		rst = 1'b0;
		wait_busy(1'b1);
		wait_busy(1'b0);
		rnd = $random(seed);
		img = '{8'h00, 8'h00, 8'h03, 8'h05, rnd, $random(seed)};
		head(8'h00);
		b(8'h02, 1'b1);
		for (int i = 0; i < 6; i++)
			b(img[i], 1'b1);
		m.stop();
		head(8'h00);
		b(8'h02, 1'b1);
		m.start();
		b(8'hD5, 1'b1);
		r(8'h5A, 1'b0);
		for (int i = 0; i < 6; i++)
			r(img[i], i == 5);
		m.stop();
		m.start();
		b(8'hA0, 1'b0);
		m.stop();
		settle();
		cmp("disabled_level", {1'b0, rnd}, {1'b0, disabled_level});
		for (int v = 0; v < 4; v++)
		begin
			wreg(8'h02, {7'h00, v[0]});
			shutdown_enable_pin = v[1];
			settle();
			cmp("out_hiz", 9'h00C, {5'h00, out_hiz});
			cmp("out_enabled", {5'h00, 4'h3 & ~(4'h5 & {4{v[1] ^ v[0]}})},
				{5'h00, out_enabled});
		end
		wreg(8'h02, 8'h02);
		cmp("global_shutdown", 9'h001, {8'h00, global_shutdown});
		shutdown_enable_pin = 1'b0;
		settle();
		cmp("out_enabled", 9'h003, {5'h00, out_enabled});
		for (int v = 0; v < 4; v++)
		begin
			wreg(8'h02, {4'h0, v[0], v[0], 2'h0});
			source_choice_pin = v[1];
			settle();
			cmp("ref", {8'h00, v[0] ^ v[1]}, {8'h00, ref_from_clock_input});
			cmp("bypass", {8'h00, v[0]}, {8'h00, crystal_bypass});
		end
		wreg(8'h02, 8'h00);
		source_choice_pin = 1'b0;
		for (int i = 0; i < 5; i++)
		begin
			wreg(8'h03, {6'h00, tab[i][3:2]});
			primary_lost = tab[i][1];
			settle();
			cmp("ref", {8'h00, tab[i][0]}, {8'h00, ref_from_clock_input});
		end
		copy(8'h01);
		wreg(8'h06, ~rnd);
		copy(8'h02);
		rnd = 8'h00;
		config_select = 3'h5;
		copy(8'h00);
		rnd = img[4];
		config_select = 3'h0;
		copy(8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
